// [diag_pkg.sv]
// Register map, field layout, timing and state constants of the diagnostic page
package diag_pkg;
  // Byte addresses on the page
  localparam logic [7:0] OFF_CAL_FIRST                 = 8'h38;
  localparam logic [7:0] OFF_CAL_LAST                  = 8'h5e;
  localparam logic [7:0] OFF_MEAS_FIRST                = 8'h60;
  localparam logic [7:0] OFF_MEAS_LAST                 = 8'h69;
  localparam logic [7:0] OFF_PIN_STATE_SOFT_CONTROL    = 8'h6e;
  localparam logic [7:0] OFF_ALARM_FLAGS_PRIMARY       = 8'h70;
  localparam logic [7:0] OFF_ALARM_FLAGS_RECEIVE_POWER = 8'h71;
  localparam logic [7:0] OFF_INPUT_EQUALIZER_SELECT    = 8'h72;
  localparam logic [7:0] OFF_OUTPUT_EMPHASIS_SELECT    = 8'h73;
  localparam logic [7:0] OFF_WARNING_FLAGS_PRIMARY     = 8'h74;
  localparam logic [7:0] OFF_WARNING_FLAGS_RX_POWER    = 8'h75;
  localparam logic [7:0] OFF_EXTENDED_SOFT_CONTROL     = 8'h76;
  localparam logic [7:0] OFF_RECOVERY_LOCK_STATUS      = 8'h77;
  // Bit positions in the control and status bytes
  localparam int BIT_TX_OFF_STATE      = 7;
  localparam int BIT_SOFT_TX_OFF       = 6;
  localparam int BIT_TX_RATE_STATE     = 5;
  localparam int BIT_RX_RATE_STATE     = 4;
  localparam int BIT_SOFT_RATE         = 3;
  localparam int BIT_LASER_FAULT       = 2;
  localparam int BIT_SIGNAL_ABSENT     = 1;
  localparam int BIT_DATA_READY_N      = 0;
  localparam int BIT_POWER_LEVEL_STATE = 1;
  localparam int BIT_TX_LOCK_LOST      = 1;
  localparam int BIT_RX_LOCK_LOST      = 0;
  localparam int FLAG_RX_HIGH          = 7;
  localparam int FLAG_RX_LOW           = 6;
  localparam int CODE_MSB              = 7;
  localparam int CODE_LSB              = 4;
  // Measurement slots, in page order
  localparam int MEAS_TEMP  = 0;
  localparam int MEAS_VCC   = 1;
  localparam int MEAS_BIAS  = 2;
  localparam int MEAS_TXPWR = 3;
  localparam int MEAS_RXPWR = 4;
  localparam int MEAS_COUNT = 5;
  // Synchronised pin slots
  localparam int PIN_TX_OFF  = 0;
  localparam int PIN_TX_RATE = 1;
  localparam int PIN_RX_RATE = 2;
  localparam int PIN_TX_LOL  = 3;
  localparam int PIN_RX_LOL  = 4;
  localparam int PIN_COUNT   = 5;
  // Reset values
  localparam logic [3:0] CODE_RESET = 4'h0;
  localparam logic       SOFT_RESET = 1'b0;
  // Soft command response time
  localparam int unsigned RESPONSE_TIME_MS = 100;
  localparam int unsigned CLK_FREQ_KHZ     = 250000;
  localparam int unsigned RESPONSE_CYCLES  = RESPONSE_TIME_MS * CLK_FREQ_KHZ;
  // Two-wire framing
  localparam logic [6:0] PAGE_DEV_ADDR = 7'h51;
  localparam logic [2:0] LAST_BIT      = 3'h7;
  typedef enum logic [2:0] {S_IDLE, S_DEV, S_WADDR, S_WDATA, S_ACK, S_RDATA, S_RACK} wire_state_t;
endpackage

// [host_link_model.sv]
// Host controller model that masters the two-wire management link
`timescale 1ns/1ps
module host_link_model (
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_low
);
  // Idle bus: clock high, data left to its pull-up
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  // Start or repeated start: data falls while clock is high
  task automatic start();
    o_sda_low = 1'b0;
    #20 o_scl = 1'b1;
    #20 o_sda_low = 1'b1;
    #20 o_scl = 1'b0;
  endtask
  // Stop: data rises while clock is high
  task automatic stop();
    o_sda_low = 1'b1;
    #20 o_scl = 1'b1;
    #20 o_sda_low = 1'b0;
    #20;
  endtask
  // Eight bits and acknowledge, MSB first; a 1 releases data for the target
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      o_sda_low = ~d[i];
      #20 o_scl = 1'b1;
      #20 q[i] = i_sda;
      #20 o_scl = 1'b0;
      #20;
    end
  endtask
endmodule

// [optical_diag_regs.sv]
// Diagnostic status and control page of the optical module
// Summary of operation
// (R01) Temperature reads as signed 16-bit, 1/256 degree per count.
// (R02) Received optical power reads as unsigned 16-bit, 0.1 uW per count.
// (R03) Supply voltage reads as unsigned 16-bit, 100 uV per count.
// (R04) Laser bias reads as unsigned 16-bit, 2 uA per count.
// (R05) Transmitted optical power reads as unsigned 16-bit, 0.1 uW per count.
// (R06) Status bit 7 shows the transmitter-off pin level.
// (R07) Status bits 5 and 4 show transmit-rate and receive-rate pins.
// (R08) Status bits 2 and 1 mirror laser fault and signal absent outputs.
// (R09) Status bit 0 reads 0 once fresh measurements exist, else 1.
// (R10) Soft bit 6 ORed with transmitter-off pin disables the transmitter.
// (R11) Soft bit 3 ORed with receive-rate pin selects high receive rate; resets 0.
// (R12) Soft command writes take effect within 100 ms.
// (R13) Byte 112 holds high/low alarms of temp, supply, bias, transmit power.
// (R14) Byte 113 holds receive power high/low alarms in bits 7 and 6.
// (R15) Byte 116 holds the same eight conditions against warning thresholds.
// (R16) Byte 117 holds receive power high/low warnings in bits 7 and 6.
// (R17) Second soft bit 3 ORed with transmit-rate pin selects high rate; resets 0.
// (R18) Power level state bit reads 0; power level select does nothing.
// (R19) Byte 119 shows transmit lock lost in bit 1, receive in bit 0.
// (R20) Equalizer byte bits 7..4 pick 0..10 dB input equalization.
// (R21) Emphasis byte bits 7..4 pick receive output emphasis code.
// (R22) Calibration bytes 56..94 return fixed factory defaults.
// (R23) Measurements sit MSB then LSB from byte 96 to byte 105.
// (R24) Reserved bits read 0 and ignore writes.
// (R25) Each flag follows its condition and clears when back in limits.
// (R26) Host writes only soft bits and code fields; flags are read-only.
`timescale 1ns/1ps
module optical_diag_regs
  import diag_pkg::*;
#(
  parameter int unsigned RESPONSE_LIMIT   = RESPONSE_CYCLES,
  parameter logic [7:0]  CAL_DEFAULT_BYTE = 8'h00,
  parameter logic [6:0]  DEV_ADDR         = PAGE_DEV_ADDR
) (
  input  wire logic                        i_mclk,
  input  wire logic                        i_rst,
  input  wire logic                        i_ce,
  input  wire logic                        i_scl,
  input  wire logic                        i_sda,
  output logic                             o_sda,
  output logic                             o_sda_oe_n,
  input  wire logic                        i_tx_off_pin,
  input  wire logic                        i_transmit_rate_pick,
  input  wire logic                        i_receive_rate_pick,
  input  wire logic                        i_tx_lock_lost_flag,
  input  wire logic                        i_rx_lock_lost_flag,
  input  wire logic                        i_laser_fault,
  input  wire logic                        i_signal_absent_output,
  input  wire logic                        i_meas_valid,
  input  wire logic [15:0]                 i_temp_meas,
  input  wire logic [15:0]                 i_vcc_meas,
  input  wire logic [15:0]                 i_bias_meas,
  input  wire logic [15:0]                 i_txpwr_meas,
  input  wire logic [15:0]                 i_rxpwr_meas,
  input  wire logic [MEAS_COUNT-1:0][15:0] i_alarm_high,
  input  wire logic [MEAS_COUNT-1:0][15:0] i_alarm_low,
  input  wire logic [MEAS_COUNT-1:0][15:0] i_warn_high,
  input  wire logic [MEAS_COUNT-1:0][15:0] i_warn_low,
  output logic                             o_tx_disable,
  output logic                             o_tx_rate_high,
  output logic                             o_rx_rate_high,
  output logic [3:0]                       o_input_equalizer_code,
  output logic [3:0]                       o_output_emphasis_code
);
  typedef struct packed {
    logic [PIN_COUNT-1:0]        pin_s1;
    logic [PIN_COUNT-1:0]        pin_s2;
    logic                        soft_tx_off;
    logic                        soft_rx_rate;
    logic                        soft_tx_rate;
    logic [3:0]                  eq_code;
    logic [3:0]                  emph_code;
    logic                        data_ready;
    logic [MEAS_COUNT-1:0][15:0] meas;
    logic [7:0]                  alarm_main;
    logic [7:0]                  warn_main;
    logic [1:0]                  alarm_rx;
    logic [1:0]                  warn_rx;
    logic                        tx_disable;
    logic                        tx_rate_high;
    logic                        rx_rate_high;
  } diag_reg_t;

  diag_reg_t   r;
  diag_reg_t   n;
  logic [7:0]  raddr;
  logic [7:0]  rdata;
  logic [7:0]  waddr;
  logic [7:0]  wdata;
  logic        wr_stb;
  logic [7:0]  status_byte;
  logic [7:0]  ext_byte;
  logic [3:0]  meas_off;
  int unsigned lag_cnt;

  // Threshold test; temperature compares signed, the rest unsigned
  function automatic logic beyond(logic [15:0] v, logic [15:0] t, logic is_signed, logic high);
    logic gt;
    logic lt;
    if (is_signed) begin
      gt = $signed(v) > $signed(t);
      lt = $signed(v) < $signed(t);
    end else begin
      gt = v > t;
      lt = v < t;
    end
    return high ? gt : lt;
  endfunction

  // Serial link engine; the page pointer and write strobes come from here
  two_wire_target #(
    .DEV_ADDR (DEV_ADDR)
  ) u_link (
    .i_mclk     (i_mclk),
    .i_rst      (i_rst),
    .i_ce       (i_ce),
    .i_scl      (i_scl),
    .i_sda      (i_sda),
    .i_rdata    (rdata),
    .o_sda      (o_sda),
    .o_sda_oe_n (o_sda_oe_n),
    .o_raddr    (raddr),
    .o_waddr    (waddr),
    .o_wdata    (wdata),
    .o_wr_stb   (wr_stb)
  );

  // Read-back of the control bytes
  always_comb begin
    status_byte                        = '0;
    status_byte[BIT_TX_OFF_STATE]      = r.pin_s2[PIN_TX_OFF];   // R06
    status_byte[BIT_SOFT_TX_OFF]       = r.soft_tx_off;
    status_byte[BIT_TX_RATE_STATE]     = r.pin_s2[PIN_TX_RATE];  // R07
    status_byte[BIT_RX_RATE_STATE]     = r.pin_s2[PIN_RX_RATE];  // R07
    status_byte[BIT_SOFT_RATE]         = r.soft_rx_rate;
    status_byte[BIT_LASER_FAULT]       = i_laser_fault;          // R08
    status_byte[BIT_SIGNAL_ABSENT]     = i_signal_absent_output; // R08
    status_byte[BIT_DATA_READY_N]      = ~r.data_ready;          // R09
    ext_byte                           = '0;                     // R24
    ext_byte[BIT_SOFT_RATE]            = r.soft_tx_rate;
    ext_byte[BIT_POWER_LEVEL_STATE]    = 1'b0;                   // R18
  end

  // Page read multiplexer
  always_comb begin
    meas_off = 4'(raddr - OFF_MEAS_FIRST);
    rdata    = '0;                                               // R24
    if (raddr >= OFF_CAL_FIRST && raddr <= OFF_CAL_LAST) begin
      rdata = CAL_DEFAULT_BYTE;                                  // R22
    end else if (raddr >= OFF_MEAS_FIRST && raddr <= OFF_MEAS_LAST) begin
      // Even offset is the high byte of a pair
      rdata = meas_off[0] ? r.meas[meas_off[3:1]][7:0] : r.meas[meas_off[3:1]][15:8]; // R23
    end else begin
      unique case (raddr)
        OFF_PIN_STATE_SOFT_CONTROL:    rdata = status_byte;
        OFF_ALARM_FLAGS_PRIMARY:       rdata = r.alarm_main;                   // R13
        OFF_ALARM_FLAGS_RECEIVE_POWER: rdata = {r.alarm_rx, 6'h00};            // R14
        OFF_INPUT_EQUALIZER_SELECT:    rdata = {r.eq_code, 4'h0};              // R20
        OFF_OUTPUT_EMPHASIS_SELECT:    rdata = {r.emph_code, 4'h0};            // R21
        OFF_WARNING_FLAGS_PRIMARY:     rdata = r.warn_main;                    // R15
        OFF_WARNING_FLAGS_RX_POWER:    rdata = {r.warn_rx, 6'h00};             // R16
        OFF_EXTENDED_SOFT_CONTROL:     rdata = ext_byte;
        OFF_RECOVERY_LOCK_STATUS:      rdata = {6'h00, r.pin_s2[PIN_TX_LOL], r.pin_s2[PIN_RX_LOL]}; // R19
        default:                       rdata = '0;
      endcase
    end
  end

  // Next state: pin sync, host writes, measurement capture, flags, outputs
  always_comb begin
    n        = r;
    n.pin_s1 = {i_rx_lock_lost_flag, i_tx_lock_lost_flag, i_receive_rate_pick,
                i_transmit_rate_pick, i_tx_off_pin};
    n.pin_s2 = r.pin_s1;
    // Host writes touch only the soft bits and code fields
    if (wr_stb) begin                                            // R26
      unique case (waddr)
        OFF_PIN_STATE_SOFT_CONTROL: begin
          n.soft_tx_off  = wdata[BIT_SOFT_TX_OFF];
          n.soft_rx_rate = wdata[BIT_SOFT_RATE];
        end
        OFF_INPUT_EQUALIZER_SELECT: n.eq_code   = wdata[CODE_MSB:CODE_LSB]; // R20
        OFF_OUTPUT_EMPHASIS_SELECT: n.emph_code = wdata[CODE_MSB:CODE_LSB]; // R21
        OFF_EXTENDED_SOFT_CONTROL:  n.soft_tx_rate = wdata[BIT_SOFT_RATE];
        default: n.eq_code = r.eq_code;
      endcase
    end
    // Fresh samples from the monitor, kept in page order
    if (i_meas_valid) begin
      n.meas[MEAS_TEMP]  = i_temp_meas;                          // R01
      n.meas[MEAS_VCC]   = i_vcc_meas;                           // R03
      n.meas[MEAS_BIAS]  = i_bias_meas;                          // R04
      n.meas[MEAS_TXPWR] = i_txpwr_meas;                         // R05
      n.meas[MEAS_RXPWR] = i_rxpwr_meas;                         // R02
      n.data_ready       = 1'b1;                                 // R09
    end
    // Flags track the held measurements, high bit first per quantity
    for (int i = 0; i < MEAS_RXPWR; i++) begin
      n.alarm_main[7 - 2 * i] = beyond(r.meas[i], i_alarm_high[i], i == MEAS_TEMP, 1'b1); // R13 R25
      n.alarm_main[6 - 2 * i] = beyond(r.meas[i], i_alarm_low[i], i == MEAS_TEMP, 1'b0);  // R13 R25
      n.warn_main[7 - 2 * i]  = beyond(r.meas[i], i_warn_high[i], i == MEAS_TEMP, 1'b1);  // R15 R25
      n.warn_main[6 - 2 * i]  = beyond(r.meas[i], i_warn_low[i], i == MEAS_TEMP, 1'b0);   // R15 R25
    end
    n.alarm_rx = {beyond(r.meas[MEAS_RXPWR], i_alarm_high[MEAS_RXPWR], 1'b0, 1'b1),
                  beyond(r.meas[MEAS_RXPWR], i_alarm_low[MEAS_RXPWR], 1'b0, 1'b0)};   // R14 R25
    n.warn_rx  = {beyond(r.meas[MEAS_RXPWR], i_warn_high[MEAS_RXPWR], 1'b0, 1'b1),
                  beyond(r.meas[MEAS_RXPWR], i_warn_low[MEAS_RXPWR], 1'b0, 1'b0)};    // R16 R25
    // Pin and soft command are ORed, acting on the next edge
    n.tx_disable   = r.soft_tx_off | r.pin_s2[PIN_TX_OFF];       // R10 R12
    n.rx_rate_high = r.soft_rx_rate | r.pin_s2[PIN_RX_RATE];     // R11
    n.tx_rate_high = r.soft_tx_rate | r.pin_s2[PIN_TX_RATE];     // R17
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      r              <= '0;
      r.soft_tx_off  <= SOFT_RESET;
      r.soft_rx_rate <= SOFT_RESET;                              // R11
      r.soft_tx_rate <= SOFT_RESET;                              // R17
      r.eq_code      <= CODE_RESET;
      r.emph_code    <= CODE_RESET;
    end else if (i_ce) begin
      r <= n;
    end
  end

  assign o_tx_disable           = r.tx_disable;
  assign o_tx_rate_high         = r.tx_rate_high;
  assign o_rx_rate_high         = r.rx_rate_high;
  assign o_input_equalizer_code = r.eq_code;
  assign o_output_emphasis_code = r.emph_code;

  // Cycles for which the transmitter-off output lags its sources
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      lag_cnt <= 0;
    end else if (i_ce) begin
      lag_cnt <= (o_tx_disable != (r.soft_tx_off | r.pin_s2[PIN_TX_OFF])) ? lag_cnt + 1 : 0;
    end
  end

  // Transmitter disable follows pin OR soft bit
  a_tx_off_or: assert property (@(posedge i_mclk) disable iff (i_rst) // R10
    $past(i_ce) |-> o_tx_disable == ($past(r.soft_tx_off) | $past(r.pin_s2[PIN_TX_OFF])))
    else $error("transmitter disable does not follow pin or soft bit");

  // Receive rate follows pin OR soft bit
  a_rx_rate_or: assert property (@(posedge i_mclk) disable iff (i_rst) // R11
    $past(i_ce) |-> o_rx_rate_high == ($past(r.soft_rx_rate) | $past(r.pin_s2[PIN_RX_RATE])))
    else $error("receive rate does not follow pin or soft bit");

  // Transmit rate follows pin OR soft bit
  a_tx_rate_or: assert property (@(posedge i_mclk) disable iff (i_rst) // R17
    $past(i_ce) |-> o_tx_rate_high == ($past(r.soft_tx_rate) | $past(r.pin_s2[PIN_TX_RATE])))
    else $error("transmit rate does not follow pin or soft bit");

  // Soft command settles well inside the response limit
  a_soft_response: assert property (@(posedge i_mclk) disable iff (i_rst) // R12
    lag_cnt < RESPONSE_LIMIT)
    else $error("soft command not acted on in time");

  // Data-ready bar drops after the first fresh sample and stays low for four cycles
  a_ready_low: assert property (@(posedge i_mclk) disable iff (i_rst) // R09
    (i_ce && i_meas_valid) |=> (status_byte[BIT_DATA_READY_N] == 1'b0) [*4])
    else $error("data ready bar not low after measurement");

  // Captured temperature lands in the temperature slot of the held measurements one cycle later
  a_meas_order: assert property (@(posedge i_mclk) disable iff (i_rst) // R23
    (i_ce && i_meas_valid) |=> r.meas[MEAS_TEMP] == $past(i_temp_meas))
    else $error("temperature sample not captured");

  // Equalizer write reaches the output code
  a_eq_write: assert property (@(posedge i_mclk) disable iff (i_rst) // R20
    (i_ce && wr_stb && waddr == OFF_INPUT_EQUALIZER_SELECT)
      |=> o_input_equalizer_code == $past(wdata[CODE_MSB:CODE_LSB]))
    else $error("equalizer code not written");

  // Reserved receive-power flag bits read zero
  a_reserved_zero: assert property (@(posedge i_mclk) disable iff (i_rst) // R24
    (raddr == OFF_ALARM_FLAGS_RECEIVE_POWER || raddr == OFF_WARNING_FLAGS_RX_POWER)
      |-> rdata[5:0] == 6'h00)
    else $error("reserved flag bits not zero");

  // Power level state always reads zero
  a_power_level: assert property (@(posedge i_mclk) disable iff (i_rst) // R18
    (raddr == OFF_EXTENDED_SOFT_CONTROL) |-> rdata[BIT_POWER_LEVEL_STATE] == 1'b0)
    else $error("power level state not zero");

  // Temperature high alarm follows the signed comparison one cycle later
  a_temp_alarm: assert property (@(posedge i_mclk) disable iff (i_rst) // R13
    i_ce |=> r.alarm_main[7] == ($signed($past(r.meas[MEAS_TEMP])) > $signed($past(i_alarm_high[MEAS_TEMP]))))
    else $error("temperature high alarm wrong");

  // Transmitter-off state bit shows the pin two edges later
  a_pin_mirror: assert property (@(posedge i_mclk) disable iff (i_rst) // R06
    ($past(i_ce) && $past(i_ce, 2) && !$past(i_rst) && !$past(i_rst, 2))
      |-> status_byte[BIT_TX_OFF_STATE] == $past(i_tx_off_pin, 2))
    else $error("transmitter-off state bit does not follow the pin");
endmodule

// [optical_diag_regs_tb.sv]
// Self-checking bench of the diagnostic page, driven over the two-wire link
`timescale 1ns/1ps
module optical_diag_regs_tb;
  import diag_pkg::*;
  logic i_mclk = 1'b0, i_rst = 1'b1, valid = 1'b0, ce = 1'b1, scl, sda_low, o_sda, o_sda_oe_n;
  logic [8:0] nq;
  logic [4:0] pins = 5'h0;
  logic [1:0] outs = 2'h0;
  logic [MEAS_COUNT-1:0][15:0] meas = '0;
  logic o_tx_disable, o_tx_rate_high, o_rx_rate_high;
  logic [3:0] eq_code, emph_code;
  wire sda = ~sda_low & (o_sda_oe_n | o_sda);
  int fails = 0, checked = 0;
  // Clock
  always #2 i_mclk = ~i_mclk;
  // Design and host model
  optical_diag_regs #(.RESPONSE_LIMIT(64), .CAL_DEFAULT_BYTE(8'h5a)) optical_diag_regs_i (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_ce(ce), .i_scl(scl), .i_sda(sda), .o_sda(o_sda),
    .o_sda_oe_n(o_sda_oe_n), .i_tx_off_pin(pins[0]), .i_transmit_rate_pick(pins[1]),
    .i_receive_rate_pick(pins[2]), .i_tx_lock_lost_flag(pins[3]), .i_rx_lock_lost_flag(pins[4]),
    .i_laser_fault(outs[1]), .i_signal_absent_output(outs[0]), .i_meas_valid(valid),
    .i_temp_meas(meas[0]), .i_vcc_meas(meas[1]), .i_bias_meas(meas[2]), .i_txpwr_meas(meas[3]),
    .i_rxpwr_meas(meas[4]), .i_alarm_high({5{16'h1000}}), .i_alarm_low({5{16'h0800}}),
    .i_warn_high({5{16'h0c00}}), .i_warn_low({5{16'h0a00}}), .o_tx_disable(o_tx_disable),
    .o_tx_rate_high(o_tx_rate_high), .o_rx_rate_high(o_rx_rate_high),
    .o_input_equalizer_code(eq_code), .o_output_emphasis_code(emph_code));
  host_link_model host_link_model_i (.i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
  // Compare and report
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Byte write; all three bytes must be acknowledged
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [8:0] q1, q2, q3;
    @(posedge i_mclk) #1;
    host_link_model_i.start();
    host_link_model_i.xfer({PAGE_DEV_ADDR, 2'b01}, q1);
    host_link_model_i.xfer({a, 1'b1}, q2);
    host_link_model_i.xfer({d, 1'b1}, q3);
    host_link_model_i.stop();
    chk({5'h0, q1[0], q2[0], q3[0]}, 8'h00);
  endtask
  // Pointer write, repeated start, one byte read with final NACK
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [8:0] q;
    @(posedge i_mclk) #1;
    host_link_model_i.start();
    host_link_model_i.xfer({PAGE_DEV_ADDR, 2'b01}, q);
    host_link_model_i.xfer({a, 1'b1}, q);
    host_link_model_i.start();
    host_link_model_i.xfer({PAGE_DEV_ADDR, 2'b11}, q);
    host_link_model_i.xfer(9'h1ff, q);
    host_link_model_i.stop();
    chk(q[8:1], exp);
  endtask
  // One-cycle capture pulse of all five measurements
  task automatic capture(input logic [79:0] v);
    @(posedge i_mclk) #1;
    meas = v;
    valid = 1'b1;
    @(posedge i_mclk) #1;
    valid = 1'b0;
  endtask
  task automatic close_out();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Hang guard
  initial begin
    #300000;
    fails++;
    $display("BAD %0t run did not finish", $time);
    close_out();
  end
  // Main sequence
  initial begin
    repeat (2) @(posedge i_mclk);
    #1 i_rst = 1'b0;
    repeat (8) @(posedge i_mclk);
    rchk(OFF_PIN_STATE_SOFT_CONTROL, 8'h01);
    pins = 5'h1f;
    outs = 2'h3;
    rchk(OFF_PIN_STATE_SOFT_CONTROL, 8'hb7);
    rchk(OFF_RECOVERY_LOCK_STATUS, 8'h03);
    chk({o_tx_disable, o_tx_rate_high, o_rx_rate_high, 5'h0}, 8'he0);
    pins = 5'h0;
    outs = 2'h0;
    capture({16'h1100, 16'h0700, 16'h0b00, 16'h0900, 16'hf000});
    for (int i = 0; i < 10; i++) rchk(OFF_MEAS_FIRST + 8'(i), (i % 2) ? meas[i/2][7:0] : meas[i/2][15:8]);
    rchk(OFF_ALARM_FLAGS_PRIMARY, 8'h41);
    rchk(OFF_ALARM_FLAGS_RECEIVE_POWER, 8'h80);
    rchk(OFF_WARNING_FLAGS_PRIMARY, 8'h51);
    rchk(OFF_WARNING_FLAGS_RX_POWER, 8'h80);
    capture({16'h0b00, 16'h0b00, 16'h0d00, 16'h0b00, 16'h1100});
    rchk(OFF_ALARM_FLAGS_PRIMARY, 8'h80);
    rchk(OFF_ALARM_FLAGS_RECEIVE_POWER, 8'h00);
    rchk(OFF_WARNING_FLAGS_PRIMARY, 8'h88);
    rchk(OFF_WARNING_FLAGS_RX_POWER, 8'h00);
    ce = 1'b0;
    capture('0);
    ce = 1'b1;
    rchk(OFF_MEAS_FIRST, 8'h11);
    wr(OFF_PIN_STATE_SOFT_CONTROL, 8'hff);
    rchk(OFF_PIN_STATE_SOFT_CONTROL, 8'h48);
    chk({o_tx_disable, o_tx_rate_high, o_rx_rate_high, 5'h0}, 8'ha0);
    wr(OFF_EXTENDED_SOFT_CONTROL, 8'hff);
    rchk(OFF_EXTENDED_SOFT_CONTROL, 8'h08);
    chk({o_tx_disable, o_tx_rate_high, o_rx_rate_high, 5'h0}, 8'he0);
    for (int c = 0; c < 16; c++) begin
      wr(OFF_INPUT_EQUALIZER_SELECT, {4'(c), 4'h5});
      wr(OFF_OUTPUT_EMPHASIS_SELECT, {4'(15 - c), 4'ha});
      chk({eq_code, emph_code}, {4'(c), 4'(15 - c)});
    end
    rchk(OFF_INPUT_EQUALIZER_SELECT, 8'hf0);
    rchk(OFF_OUTPUT_EMPHASIS_SELECT, 8'h00);
    rchk(OFF_CAL_FIRST, 8'h5a);
    rchk(OFF_CAL_LAST, 8'h5a);
    rchk(8'h6f, 8'h00);
    host_link_model_i.start();
    host_link_model_i.xfer({~PAGE_DEV_ADDR, 2'b01}, nq);
    host_link_model_i.stop();
    chk({7'h0, nq[0]}, 8'h01);
    @(posedge i_mclk) #1 i_rst = 1'b1;
    repeat (2) @(posedge i_mclk);
    #1 i_rst = 1'b0;
    repeat (8) @(posedge i_mclk);
    rchk(OFF_PIN_STATE_SOFT_CONTROL, 8'h01);
    rchk(OFF_EXTENDED_SOFT_CONTROL, 8'h00);
    chk({eq_code, emph_code}, {CODE_RESET, CODE_RESET});
    chk({o_tx_disable, o_tx_rate_high, o_rx_rate_high, 5'h0}, 8'h00);
    close_out();
  end
endmodule

// [two_wire_target.sv]
// Two-wire serial target: framing, acknowledge and byte pointer of the page
`timescale 1ns/1ps
module two_wire_target
  import diag_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = PAGE_DEV_ADDR
) (
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  input  wire logic       i_ce,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  input  wire logic [7:0] i_rdata,
  output logic            o_sda,
  output logic            o_sda_oe_n,
  output logic [7:0]      o_raddr,
  output logic [7:0]      o_waddr,
  output logic [7:0]      o_wdata,
  output logic            o_wr_stb
);
  typedef struct packed {
    logic [1:0]  line_s1;
    logic [1:0]  line_s2;
    logic [1:0]  line_q;
    wire_state_t state;
    wire_state_t after;
    logic [2:0]  cnt;
    logic [7:0]  sh;
    logic [7:0]  ptr;
    logic        full;
    logic        drive;
    logic        wr_stb;
    logic [7:0]  waddr;
    logic [7:0]  wdata;
  } wire_reg_t;

  wire_reg_t r;
  wire_reg_t n;

  // Load a byte for the host to read and step the pointer
  function automatic wire_reg_t load_read(wire_reg_t s, logic [7:0] d);
    wire_reg_t t;
    t       = s;
    t.sh    = d;
    t.drive = ~d[7];
    t.ptr   = s.ptr + 8'h01;
    t.cnt   = '0;
    t.full  = 1'b0;
    t.state = S_RDATA;
    return t;
  endfunction

  // Line sampling, start/stop detection and byte sequencing
  always_comb begin
    logic scl;
    logic sda;
    logic rise;
    logic fall;
    scl  = r.line_s2[1];
    sda  = r.line_s2[0];
    rise = scl & ~r.line_q[1];
    fall = ~scl & r.line_q[1];
    n         = r;
    n.line_s1 = {i_scl, i_sda};
    n.line_s2 = r.line_s1;
    n.line_q  = r.line_s2;
    n.wr_stb  = 1'b0;
    if (scl && r.line_q[1] && r.line_q[0] && !sda) begin
      n.state = S_DEV;
      n.cnt   = '0;
      n.full  = 1'b0;
      n.drive = 1'b0;
    end else if (scl && r.line_q[1] && !r.line_q[0] && sda) begin
      n.state = S_IDLE;
      n.drive = 1'b0;
    end else begin
      unique case (r.state)
        S_IDLE: begin
          n.drive = 1'b0;
        end
        S_DEV, S_WADDR, S_WDATA: begin
          if (rise) begin
            n.sh   = {r.sh[6:0], sda};
            n.cnt  = r.cnt + 3'h1;
            n.full = (r.cnt == LAST_BIT);
          end else if (fall && r.full) begin
            n.full  = 1'b0;
            n.drive = 1'b1;
            n.state = S_ACK;
            n.after = S_WDATA;
            if (r.state == S_DEV) begin
              n.after = r.sh[0] ? S_RDATA : S_WADDR;
              if (r.sh[7:1] != DEV_ADDR) begin
                n.drive = 1'b0;
                n.state = S_IDLE;
              end
            end else if (r.state == S_WADDR) begin
              n.ptr = r.sh;
            end else begin
              n.wr_stb = 1'b1;
              n.waddr  = r.ptr;
              n.wdata  = r.sh;
              n.ptr    = r.ptr + 8'h01;
            end
          end
        end
        S_ACK: begin
          if (fall) begin
            if (r.after == S_RDATA) begin
              n = load_read(n, i_rdata);
            end else begin
              n.drive = 1'b0;
              n.cnt   = '0;
              n.state = r.after;
            end
          end
        end
        S_RDATA: begin
          if (fall) begin
            if (r.cnt == LAST_BIT) begin
              n.drive = 1'b0;
              n.state = S_RACK;
            end else begin
              n.cnt   = r.cnt + 3'h1;
              n.sh    = {r.sh[6:0], 1'b0};
              n.drive = ~r.sh[6];
            end
          end
        end
        S_RACK: begin
          if (rise) begin
            n.full = ~sda;
          end else if (fall) begin
            n.state = S_IDLE;
            if (r.full) begin
              n = load_read(n, i_rdata);
            end
          end
        end
        default: begin
          n.state = S_IDLE;
        end
      endcase
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      r <= '{line_s1: 2'h3, line_s2: 2'h3, line_q: 2'h3, state: S_IDLE, after: S_IDLE, default: '0};
    end else if (i_ce) begin
      r <= n;
    end
  end

  assign o_sda      = 1'b0;
  assign o_sda_oe_n = ~r.drive;
  assign o_raddr    = r.ptr;
  assign o_waddr    = r.waddr;
  assign o_wdata    = r.wdata;
  assign o_wr_stb   = r.wr_stb;
endmodule
